//--- rtl/led_string_ctrl.sv
// Purpose: gate drive, fault handling and supply optimizers
// Assumes: comparators and pins are asynchronous to clk_in
// Notes: fault pin is open drain, low enable drives it
`timescale 1ns/1ps
`include "led_ctrl_defines.svh"
module led_string_ctrl #(
	parameter int STEP_HOLD = `STEP_HOLD_CYC
) (
	input  wire logic                clk_in,
	input  wire logic                rst_n_in,
	input  wire led_ctrl_pkg::lane_t pwm_in,
	input  wire logic                enable_in,
	input  wire logic                single_pwm_mode_in,
	input  wire led_ctrl_pkg::lane_t short_det_in,
	input  wire led_ctrl_pkg::lane_t open_det_in,
	input  wire led_ctrl_pkg::lane_t regulation_ok_in,
	input  wire led_ctrl_pkg::lane_t string_enable_in,
	input  wire logic                over_temp_in,
	input  wire logic                temp_recovered_in,
	input  wire logic                foldback_en_in,
	input  wire logic                level_wr_in,
	input  wire led_ctrl_pkg::byte_t level_data_in,
	output logic                     fault_out_n_out,
	output logic                     fault_oe_n_out,
	output led_ctrl_pkg::lane_t      gate_drive_outputs_out,
	output led_ctrl_pkg::lane_t      short_flags_out,
	output led_ctrl_pkg::lane_t      open_flags_out,
	output led_ctrl_pkg::lane_t      foldback_out,
	output led_ctrl_pkg::byte_t      feedback_current_out_a_out,
	output led_ctrl_pkg::byte_t      feedback_current_out_b_out,
	output led_ctrl_pkg::byte_t      string_current_level_out,
	output logic                     running_out
);
	import led_ctrl_pkg::*;

	if (STEP_HOLD < 1 || STEP_HOLD >= (1 << `HOLD_W)) begin : g_bad_hold
		$error("STEP_HOLD out of range");
	end

	localparam logic [`HOLD_W-1:0] HOLD_LD = `HOLD_W'(STEP_HOLD - 1);
	localparam logic [`VERIFY_W-1:0] VFY_LD = `VERIFY_W'(`VERIFY_CYC - 1);

	state_t q;
	state_t n;
	pins_t  pins;

	// Multiple of a quarter frame for string k
	function automatic logic [`FRAME_W-1:0] stagger(
		input logic [1:0]          k,
		input logic [`FRAME_W-1:0] qf
	);
		logic [`FRAME_W-1:0] r;
		r = '0;
		unique case (k)
			2'h0: r = '0;
			2'h1: r = qf;
			2'h2: r = qf << 1;
			2'h3: r = qf + (qf << 1);
		endcase
		return r;
	endfunction

	assign pins = '{pwm: pwm_in, en: enable_in,
		single: single_pwm_mode_in, sc_cmp: short_det_in,
		oc_cmp: open_det_in, reg_ok: regulation_ok_in,
		str_en: string_enable_in, hot: over_temp_in,
		cool: temp_recovered_in, fold_en: foldback_en_in};

	always_comb begin
		logic                p0;
		logic [`FRAME_W-1:0] qf;
		logic                src;
		logic                mon0;
		logic                mon1;
		logic                starved;
		n = q;
		p0 = q.s2.pwm[0];
		qf = q.period >> 2;
		src = 1'b0;
		mon0 = 1'b0;
		mon1 = 1'b0;
		starved = 1'b0;
		n.s1 = pins;
		n.s2 = q.s1;
		// Hysteresis between the two temperature comparators
		if (q.s2.hot) begin
			n.thermal = 1'b1;
		end else if (q.s2.cool) begin
			n.thermal = 1'b0;
		end
		n.active = q.s2.en && !n.thermal;
		n.p0_prev = p0;
		// Frame length measured rising edge to rising edge
		if (p0 && !q.p0_prev) begin
			n.period = q.pcount;
			n.pcount = '0;
		end else if (q.pcount != '1) begin
			n.pcount = q.pcount + 1'b1;
		end
		// One pending rise and one pending fall per string: delay stays under a frame
		for (int k = 1; k < 4; k++) begin
			if (q.rise_p[k]) begin
				if (q.rise_t[k] == '0) begin
					n.dly[k] = 1'b1;
					n.rise_p[k] = 1'b0;
				end else begin
					n.rise_t[k] = q.rise_t[k] - 1'b1;
				end
			end
			if (q.fall_p[k]) begin
				if (q.fall_t[k] == '0) begin
					n.dly[k] = 1'b0;
					n.fall_p[k] = 1'b0;
				end else begin
					n.fall_t[k] = q.fall_t[k] - 1'b1;
				end
			end
			if (p0 != q.p0_prev) begin
				if (p0) begin
					n.rise_p[k] = 1'b1;
					n.rise_t[k] = stagger(2'(k), qf);
				end else begin
					n.fall_p[k] = 1'b1;
					n.fall_t[k] = stagger(2'(k), qf);
				end
			end
		end
		for (int k = 0; k < 4; k++) begin
			if (q.s2.single) begin
				src = (k == 0) ? p0 : q.dly[k];
			end else begin
				src = q.s2.pwm[k];
			end
			// Faults only judged while the string conducts
			if (q.gate[k] && (q.s2.sc_cmp[k] || q.s2.oc_cmp[k])) begin
				if (q.vcnt[k] == VFY_LD) begin
					n.sc[k] = q.sc[k] | q.s2.sc_cmp[k];
					n.oc[k] = q.oc[k] | q.s2.oc_cmp[k];
				end else begin
					n.vcnt[k] = q.vcnt[k] + 1'b1;
				end
			end else begin
				n.vcnt[k] = '0;
			end
			n.fold[k] = q.s2.fold_en && q.gate[k]
				&& q.s2.sc_cmp[k];
			n.gate[k] = n.active && q.s2.str_en[k] && src
				&& !n.sc[k] && !n.oc[k];
		end
		// Strings 0,1 feed optimizer a, strings 2,3 feed b
		for (int e = 0; e < 2; e++) begin
			mon0 = q.s2.str_en[2*e] && !q.sc[2*e] && !q.oc[2*e];
			mon1 = q.s2.str_en[2*e+1] && !q.sc[2*e+1]
				&& !q.oc[2*e+1];
			starved = (mon0 && q.gate[2*e] && !q.s2.reg_ok[2*e])
				|| (mon1 && q.gate[2*e+1]
				&& !q.s2.reg_ok[2*e+1]);
			if (!mon0 && !mon1) begin
				// Nothing to watch: supply left at its maximum
				n.dac[e] = '0;
				n.phase[e] = EO_OFF;
			end else if (q.hold[e] != '0) begin
				n.hold[e] = q.hold[e] - 1'b1;
			end else if (starved && q.dac[e] != '0) begin
				n.dac[e] = q.dac[e] - 1'b1;
				n.phase[e] = EO_UP;
				n.hold[e] = HOLD_LD;
			end else begin
				unique case (q.phase[e])
					EO_OFF: begin
						n.phase[e] = EO_DOWN;
					end
					EO_DOWN: begin
						if (starved || q.dac[e] == `DAC_MAX) begin
							n.phase[e] = EO_TRACK;
						end else begin
							n.dac[e] = q.dac[e] + 1'b1;
							n.hold[e] = HOLD_LD;
						end
					end
					EO_UP: begin
						n.phase[e] = EO_TRACK;
						n.reopt[e] = '0;
					end
					EO_TRACK: begin
						n.hold[e] = HOLD_LD;
						if (q.reopt[e] == `REOPT_STEPS) begin
							n.reopt[e] = '0;
							n.phase[e] = EO_DOWN;
						end else begin
							n.reopt[e] = q.reopt[e] + 1'b1;
						end
					end
				endcase
			end
		end
		if (n.active && !q.active) begin
			n.level = `LEVEL_RST;
		end else if (level_wr_in && q.active) begin
			n.level = level_data_in;
		end
		if (!n.active) begin
			// Off state equals power-up: faults and search restart
			n.sc = '0;
			n.oc = '0;
			n.vcnt = '0;
			n.gate = '0;
			n.fold = '0;
			n.dac = '0;
			n.hold = '0;
			n.phase[0] = EO_OFF;
			n.phase[1] = EO_OFF;
			n.reopt = '0;
		end
		n.fault_oe_n = !(|(n.sc | n.oc));
	end

	always_ff @(posedge clk_in) begin
		if (!rst_n_in) begin
			q <= '0;
			q.level <= `LEVEL_RST;
			q.fault_oe_n <= 1'b1;
			q.phase[0] <= EO_OFF;
			q.phase[1] <= EO_OFF;
		end else begin
			q <= n;
		end
	end

	// Open drain: data fixed low, the enable alone pulls the line
	assign fault_out_n_out = 1'b0;
	assign fault_oe_n_out = q.fault_oe_n;
	assign gate_drive_outputs_out = q.gate;
	assign short_flags_out = q.sc;
	assign open_flags_out = q.oc;
	assign foldback_out = q.fold;
	assign feedback_current_out_a_out = q.dac[0];
	assign feedback_current_out_b_out = q.dac[1];
	assign string_current_level_out = q.level;
	assign running_out = q.active;

	// Checks read registered state, so raw pin edges cannot trip them
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!rst_n_in);

	AST_OFF_NO_GATE: assert property (!q.active |-> q.gate == '0)
		else $error("gate on while off");
	AST_HOT_OFF: assert property (q.s2.hot |=> !q.active)
		else $error("no thermal shutdown");
	AST_COOL_WAIT: assert property (q.thermal && !q.s2.cool
		|=> !q.active)
		else $error("restart before recovery");
	AST_FAULT_PIN: assert property (|(q.sc | q.oc) |-> !q.fault_oe_n)
		else $error("fault pin not driven");
	AST_PIN_RELEASE: assert property ((q.sc | q.oc) == '0
		|-> q.fault_oe_n)
		else $error("fault pin held without fault");
	AST_SHORT_OFF: assert property (q.sc[1] |-> !q.gate[1])
		else $error("shorted string still driven");
	AST_OPEN_OFF: assert property (q.oc[2] |-> !q.gate[2])
		else $error("open string still driven");
	AST_VERIFY: assert property ($rose(q.sc[0])
		|-> $past(q.vcnt[0]) == VFY_LD)
		else $error("short flagged before verify time");
	AST_VERIFY_OPEN: assert property ($rose(q.oc[2])
		|-> $past(q.vcnt[2]) == VFY_LD)
		else $error("open flagged before verify time");
	AST_GATE_EN: assert property (!q.s2.str_en[3] |=> !q.gate[3])
		else $error("disabled string driven");
	AST_FOLD_OFF: assert property (!q.s2.fold_en |=> q.fold == '0)
		else $error("fold-back without enable");
	AST_OPT_A_IDLE: assert property ((q.sc[0] || q.oc[0])
		&& (q.sc[1] || q.oc[1]) |=> q.dac[0] == '0)
		else $error("optimizer a still stepping");
	AST_MULTI: assert property (q.active && !q.s2.single
		&& q.s2.str_en[2] && q.sc[2] == 1'b0 && q.oc[2] == 1'b0
		&& $stable(q.active) |=> q.gate[2] == $past(q.s2.pwm[2])
		|| q.sc[2] || q.oc[2] || !q.active)
		else $error("direct drive mismatch");
	AST_S0_DIRECT: assert property (q.active && q.s2.single
		&& q.s2.str_en[0] && !q.sc[0] && !q.oc[0]
		|=> q.gate[0] == $past(q.s2.pwm[0]) || q.sc[0] || q.oc[0]
		|| !q.active)
		else $error("string zero delayed");
	AST_LEVEL_DEF: assert property ($rose(q.active)
		|-> q.level == `LEVEL_RST)
		else $error("level not defaulted");
	AST_DAC_HOLD: assert property (q.active && $past(q.active)
		&& q.dac[0] != $past(q.dac[0]) && q.dac[0] != '0
		|-> $past(q.hold[0]) == '0)
		else $error("dac stepped early");
	AST_RESTART: assert property ($rose(q.active)
		|-> q.sc == '0 && q.oc == '0)
		else $error("fault survived restart");
	AST_REOPT: assert property (q.phase[0] == EO_TRACK
		&& q.reopt[0] == `REOPT_STEPS && q.hold[0] == '0
		|=> q.phase[0] != EO_TRACK)
		else $error("no periodic re-search");

	COV_SHORT: cover property (q.active ##1 q.sc != '0);
	COV_OPEN: cover property (q.active ##1 q.oc != '0);
	COV_STEP_UP: cover property (q.phase[0] == EO_UP);
	COV_DELAY: cover property (q.s2.single && q.gate[3]);
	COV_RESEARCH: cover property (q.phase[0] == EO_TRACK
		##1 q.phase[0] == EO_DOWN);
endmodule // led_string_ctrl

//--- rtl/led_ctrl_defines.svh
// Purpose: constants of the four-string LED driver control block
// Assumes: 10 MHz clock
// Notes: timing counts derive from the printed times
//
// Contract
// - Single input: quarter-frame progressive string delay
// - Single input: string zero follows input directly
// - Multi input: each input drives own string
// - Any verified fault pulls fault pin low
// - Verified short disables string, leaves optimizer
// - Short detect at drain comparator threshold
// - Verified open disables string, leaves optimizer
// - Enable low-high clears faults, full restart
// - Persisting faults are detected again
// - Per-string fault flags readable
// - Over-temperature acts like enable low
// - Cool-down below recovery restarts as power-up
// - Start-up lowers supply to regulation minimum
// - Optimizer repeats its search periodically
// - Lost regulation raises supply until restored
// - Feedback DAC codes 0 to 255
// - Strings 0,1 optimizer a; 2,3 optimizer b
// - Each DAC step held step-hold time
// - String current level defaults to 127
// - Fold-back changes response while short suspected
// - Works stand-alone without serial interface
// - Registers return to default on enable high
`ifndef LED_CTRL_DEFINES_SVH
`define LED_CTRL_DEFINES_SVH
`define CLK_PERIOD_NS 100
`define STEP_HOLD_MS 4
`define STEP_HOLD_CYC (`STEP_HOLD_MS * 1000000 / `CLK_PERIOD_NS)
`define VERIFY_US 10
`define VERIFY_CYC (`VERIFY_US * 1000 / `CLK_PERIOD_NS)
`define VERIFY_W 8
`define HOLD_W 16
`define FRAME_W 20
`define REOPT_STEPS 8'hFA
`define DAC_MAX 8'hFF
`define LEVEL_OFS 8'h0E
`define LEVEL_RST 8'h7F
`endif

//--- rtl/led_ctrl_pkg.sv
// Purpose: types of the LED driver control block
// Assumes: widths from led_ctrl_defines.svh
// Notes: one state struct holds all flip-flops
`include "led_ctrl_defines.svh"
package led_ctrl_pkg;
	typedef logic [7:0] byte_t;
	typedef logic [3:0] lane_t;
	typedef enum logic [1:0] {EO_OFF, EO_DOWN, EO_UP, EO_TRACK} eo_t;
	typedef struct packed {
		lane_t pwm;
		logic  en;
		logic  single;
		lane_t sc_cmp;
		lane_t oc_cmp;
		lane_t reg_ok;
		lane_t str_en;
		logic  hot;
		logic  cool;
		logic  fold_en;
	} pins_t;
	typedef struct packed {
		pins_t                           s1;
		pins_t                           s2;
		logic                            thermal;
		logic                            active;
		lane_t                           gate;
		lane_t                           sc;
		lane_t                           oc;
		lane_t                           fold;
		logic                            fault_oe_n;
		logic [3:0][`VERIFY_W-1:0]       vcnt;
		logic                            p0_prev;
		logic [`FRAME_W-1:0]             period;
		logic [`FRAME_W-1:0]             pcount;
		logic [3:0][`FRAME_W-1:0]        rise_t;
		logic [3:0][`FRAME_W-1:0]        fall_t;
		lane_t                           rise_p;
		lane_t                           fall_p;
		lane_t                           dly;
		logic [1:0][7:0]                 dac;
		logic [1:0][`HOLD_W-1:0]         hold;
		eo_t  [1:0]                      phase;
		logic [1:0][7:0]                 reopt;
		byte_t                           level;
	} state_t;
endpackage

//--- verification/led_load_model.sv
// Purpose: LED strings, MOSFETs and string supplies behind the block
// Assumes: comparators only see a string while its gate is on
// Notes: supply starves a string once its DAC code passes a limit
`timescale 1ns/1ps
module led_load_model #(
	parameter int LIMIT_A = 40,
	parameter int LIMIT_B = 60
) (
	input  wire led_ctrl_pkg::lane_t gate_in,
	input  wire led_ctrl_pkg::lane_t inject_short_in,
	input  wire led_ctrl_pkg::lane_t inject_open_in,
	input  wire led_ctrl_pkg::byte_t dac_a_in,
	input  wire led_ctrl_pkg::byte_t dac_b_in,
	output led_ctrl_pkg::lane_t      short_det_out,
	output led_ctrl_pkg::lane_t      open_det_out,
	output led_ctrl_pkg::lane_t      reg_ok_out
);
	import led_ctrl_pkg::*;
	// Drain rises past threshold only while the FET sinks
	assign short_det_out = gate_in & inject_short_in;
	assign open_det_out  = gate_in & inject_open_in;
	// More feedback current lowers supply, too far starves
	assign reg_ok_out = {{2{dac_b_in <= LIMIT_B}},
		{2{dac_a_in <= LIMIT_A}}};
endmodule // led_load_model

//--- verification/led_string_ctrl_tb.sv
// Purpose: self-checking bench of the LED string control block
// Assumes: short step-hold so the optimizers settle quickly
// Notes: register access is the plain level port
`timescale 1ns/1ps
module led_string_ctrl_tb;
	import led_ctrl_pkg::*;
	logic  clk_in, rst_n_in, enable_in, single_pwm_mode_in;
	logic  over_temp_in, temp_recovered_in, foldback_en_in, level_wr_in;
	lane_t pwm_in, string_enable_in, inj_short, inj_open;
	lane_t short_det, open_det, reg_ok, gate, sc_f, oc_f, fold;
	byte_t level_data_in, dac_a, dac_b, level;
	logic  fault_n, fault_oe_n, running;
	int    fail_count, samples_checked, cycles, n1, n2;
	led_string_ctrl #(.STEP_HOLD(20)) led_string_ctrl_i (
		.clk_in(clk_in), .rst_n_in(rst_n_in), .pwm_in(pwm_in),
		.enable_in(enable_in), .single_pwm_mode_in(single_pwm_mode_in),
		.short_det_in(short_det), .open_det_in(open_det),
		.regulation_ok_in(reg_ok), .string_enable_in(string_enable_in),
		.over_temp_in(over_temp_in), .temp_recovered_in(temp_recovered_in),
		.foldback_en_in(foldback_en_in), .level_wr_in(level_wr_in),
		.level_data_in(level_data_in), .fault_out_n_out(fault_n),
		.fault_oe_n_out(fault_oe_n), .gate_drive_outputs_out(gate),
		.short_flags_out(sc_f), .open_flags_out(oc_f),
		.foldback_out(fold), .feedback_current_out_a_out(dac_a),
		.feedback_current_out_b_out(dac_b),
		.string_current_level_out(level), .running_out(running));
	led_load_model #(.LIMIT_A(40), .LIMIT_B(60)) led_load_model_i (
		.gate_in(gate), .inject_short_in(inj_short),
		.inject_open_in(inj_open), .dac_a_in(dac_a), .dac_b_in(dac_b),
		.short_det_out(short_det), .open_det_out(open_det),
		.reg_ok_out(reg_ok));
	initial begin
		clk_in = 1'b0;
		forever #50 clk_in = ~clk_in;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge clk_in);
		#10;
	endtask
	task automatic chk(input string nm, input byte_t exp, input byte_t got);
		samples_checked++;
		if (got !== exp) begin
			fail_count++;
			$display("Error %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic chk_rng(input string nm, input int lo, input int hi,
		input byte_t got);
		samples_checked++;
		if ($isunknown(got) || got < lo || got > hi) begin
			fail_count++;
			$display("Error %s expected %0d..%0d seen %h", nm, lo, hi, got);
		end
	endtask
	task automatic finish_test();
		$display("checks %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// Far too long a run means a hang
	always @(posedge clk_in) begin
		cycles++;
		if (cycles == 20000) begin
			fail_count++;
			finish_test();
		end
	end
	initial begin
		{fail_count, samples_checked, cycles} = '0;
		{rst_n_in, enable_in, single_pwm_mode_in, over_temp_in} = '0;
		{temp_recovered_in, foldback_en_in, level_wr_in} = '0;
		{pwm_in, string_enable_in, inj_short, inj_open} = '0;
		level_data_in = 8'h00;
		tick(3);
		rst_n_in = 1'b1;
		chk("oe_n", 8'h01, fault_oe_n);
		chk("level", 8'h7F, level);
		enable_in = 1'b1;
		string_enable_in = 4'hF;
		pwm_in = 4'hE;
		tick(8);
		chk("gate", 8'h0E, gate);
		string_enable_in = 4'h7;
		tick(4);
		chk("gate", 8'h06, gate);
		string_enable_in = 4'hF;
		pwm_in = 4'hF;
		level_data_in = 8'h20;
		level_wr_in = 1'b1;
		tick(1);
		level_wr_in = 1'b0;
		chk("level", 8'h20, level);
		$display("test gates and level done");
		tick(3000);
		chk_rng("dac_a", 39, 42, dac_a);
		chk_rng("dac_b", 59, 62, dac_b);
		$display("test optimizer done");
		foldback_en_in = 1'b1;
		inj_short = 4'h3;
		inj_open = 4'h4;
		tick(20);
		chk("fold", 8'h03, fold);
		tick(130);
		chk("short", 8'h03, sc_f);
		chk("open", 8'h04, oc_f);
		chk("gate", 8'h08, gate);
		chk("oe_n", 8'h00, fault_oe_n);
		chk("fault_n", 8'h00, fault_n);
		chk("fold", 8'h00, fold);
		tick(50);
		chk("dac_a", 8'h00, dac_a);
		enable_in = 1'b0;
		tick(6);
		enable_in = 1'b1;
		tick(8);
		chk("short", 8'h00, sc_f);
		chk("level", 8'h7F, level);
		tick(150);
		chk("short", 8'h03, sc_f);
		$display("test faults done");
		{inj_short, inj_open} = '0;
		enable_in = 1'b0;
		tick(6);
		enable_in = 1'b1;
		tick(10);
		chk("run", 8'h01, running);
		over_temp_in = 1'b1;
		tick(6);
		chk("run", 8'h00, running);
		chk("gate", 8'h00, gate);
		over_temp_in = 1'b0;
		tick(10);
		chk("run", 8'h00, running);
		temp_recovered_in = 1'b1;
		tick(8);
		chk("run", 8'h01, running);
		$display("test thermal done");
		single_pwm_mode_in = 1'b1;
		pwm_in = 4'h0;
		tick(10);
		fork
			repeat (6) begin
				pwm_in = 4'h1;
				tick(200);
				pwm_in = 4'h0;
				tick(200);
			end
			begin
				tick(1050);
				n1 = 0;
				n2 = 0;
				while (gate[0] !== 1'b1 && n1 < 500) begin
					tick(1);
					n1++;
				end
				n1 = 0;
				while (gate[2] !== 1'b1 && n2 < 500) begin
					tick(1);
					n2++;
					if (gate[1] !== 1'b1)
						n1++;
				end
			end
		join
		chk_rng("delay1", 99, 102, n1);
		chk_rng("delay2", 199, 202, n2);
		$display("test phase spread done");
		// Re-search steps one code past the model's limit, then backs off
		single_pwm_mode_in = 1'b0;
		pwm_in = 4'hF;
		n1 = 0;
		repeat (6000) begin
			tick(1);
			if (dac_a === 8'h29)
				n1++;
		end
		chk_rng("research", 1, 45, n1);
		$display("test re-search done");
		finish_test();
	end
endmodule // led_string_ctrl_tb
